// [hw/swr_pkg.sv]
// package for the selective-wake fast-rate and trim register bank
// How it works
// [R1] each payload byte register holds a full read/write byte, bit 0 least significant
// [R2] tolerance control bits 7 and 6 ignore writes and read zero
// [R3] error counter inhibit stops counter only while tolerance mode is enabled
// [R4] hardware clears error counter inhibit when bus silence timeout expires
// [R5] receive filter bypass routes bus data around the analog receive filter
// [R6] dominant filter time codes 0-6 give 50-350 ns, code 7 gives 775 ns; here code 7 counts 77 clocks, 770 ns
// [R7] dominant filter stays active whatever the bypass setting
// [R8] tolerance control bit 0 enables fast-rate tolerant mode
// [R9] fine trim byte is writable only while trim enable code is 11
// [R10] fine trim bits 4:0 form a 32-step monotonic slower-to-faster range
// [R11] host leaves fine trim bits 7:5 unchanged
// [R12] options bit 7 selects standard or low-power wake receiver, gated by trim enable
// [R13] host is advised to choose the low-power receiver
// [R14] host writes coarse trim back unchanged when changing receiver selection
// [R15] options bits 4:0 hold coarse trim 12:8, writable only with trim enable 11
// [R16] calibration high and low are read-only, zero on power-on, kept on restart
// [R17] tolerance control clears on power-on; restart clears bits 7:6, keeps 5:0
// [R18] options clear bits 7:5 on power-on; restart clears bits 6:5, keeps rest
// [R19] gated trim and receiver fields ignore writes while trim enable differs from 11
package swr_pkg;
	// printed offsets are not word multiples, so byte address is four times the index
	localparam logic [7:0] SWR_IDX_PAYLOAD_ONE = 8'h32;
	localparam logic [7:0] SWR_IDX_PAYLOAD_ZERO = 8'h33;
	localparam logic [7:0] SWR_IDX_TOLERANCE = 8'h34;
	localparam logic [7:0] SWR_IDX_FINE_TRIM = 8'h38;
	localparam logic [7:0] SWR_IDX_OPTIONS = 8'h39;
	localparam logic [7:0] SWR_IDX_CAL_HIGH = 8'h3a;
	localparam logic [7:0] SWR_IDX_CAL_LOW = 8'h3b;
	localparam logic [7:0] SWR_IDX_TRIM_ENABLE = 8'h40;
	localparam logic [7:0] SWR_IDX_STATUS = 8'h41;

	localparam int SWR_BIT_ERR_INHIBIT = 5;
	localparam int SWR_BIT_FILTER_BYPASS = 4;
	localparam int SWR_BIT_FILTER_LSB = 1;
	localparam int SWR_BIT_TOL_ENABLE = 0;
	localparam int SWR_BIT_RX_SELECT = 7;
	localparam logic [7:0] SWR_TOL_WRITE_MASK = 8'h3f;
	localparam logic [7:0] SWR_TOL_RESTART_KEEP = 8'h3f;
	localparam logic [7:0] SWR_OPT_WRITE_MASK = 8'h9f;
	localparam logic [7:0] SWR_OPT_POR_KEEP = 8'h1f;
	localparam logic [7:0] SWR_OPT_RESTART_KEEP = 8'h9f;
	localparam logic [1:0] SWR_TRIM_UNLOCK = 2'h3;
	localparam logic [7:0] SWR_RESET_ZERO = 8'h00;
	// trim fields have no defined power-on value; this is the chosen neutral start
	localparam logic [7:0] SWR_FINE_TRIM_INIT = 8'h10;
	localparam logic [4:0] SWR_COARSE_TRIM_INIT = 5'h10;

	// dominant filter suppression times
	localparam int SWR_FILTER_STEP_NS = 50;
	localparam int SWR_FILTER_LONG_NS = 775;
	localparam int SWR_CLK_PERIOD_NS = 10;
	localparam int SWR_FILTER_STEP_CYC = SWR_FILTER_STEP_NS / SWR_CLK_PERIOD_NS;
	localparam int SWR_FILTER_LONG_CYC = SWR_FILTER_LONG_NS / SWR_CLK_PERIOD_NS;
	localparam logic [2:0] SWR_FILTER_LONG_CODE = 3'h7;

	typedef struct packed {
		logic errInhibit;
		logic filterBypass;
		logic [2:0] filterTime;
		logic tolEnable;
	} swr_tol_t;

	typedef struct packed {
		logic [7:0] adr;
		logic we;
		logic [3:0] sel;
		logic [31:0] dat;
	} swr_req_t;

	typedef enum logic [1:0] {SWR_IDLE, SWR_ACK} swr_bus_t;
endpackage

// [hw/swr_regs.sv]
// selective-wake payload, fast-rate tolerance, trim and calibration registers
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
// two-flop synchroniser for one pin from outside the clock domain
module swr_sync import swr_pkg::*; #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pinIn,
	output logic pinSync
);
	logic firstStage, next_firstStage;
	logic secondStage, next_secondStage;

	// only the second stage is read; the first may still be settling
	always_comb begin
		next_firstStage = pinIn;
		next_secondStage = firstStage;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			firstStage <= RESET_LEVEL;
			secondStage <= RESET_LEVEL;
		end else begin
			firstStage <= next_firstStage;
			secondStage <= next_secondStage;
		end
	end

	assign pinSync = secondStage;
endmodule

module swr_regs import swr_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic restart,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [9:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatIn,
	output logic [31:0] wbDatOut,
	output logic wbAck,
	input wire logic silenceExpired,
	input wire logic frameError,
	input wire logic rxAnalog,
	input wire logic rxFiltered,
	input wire logic calValid,
	input wire logic [7:0] calHighIn,
	input wire logic [7:0] calLowIn,
	output logic rxData,
	output logic errorCountEnable,
	output logic [7:0] errorCount,
	output logic lowPowerReceiver,
	output logic [12:0] oscillatorTrim
);
	swr_req_t req;
	swr_bus_t state, next_state;
	logic [31:0] rdData, next_rdData;
	logic [31:0] readWord;
	logic [7:0] payloadOne, next_payloadOne;
	logic [7:0] payloadZero, next_payloadZero;
	swr_tol_t tol, next_tol;
	logic [7:0] fineTrim, next_fineTrim;
	logic rxSelect, next_rxSelect;
	logic [4:0] coarseTrim, next_coarseTrim;
	logic [1:0] trimEnable, next_trimEnable;
	logic [7:0] calHigh, next_calHigh;
	logic [7:0] calLow, next_calLow;
	logic [7:0] errCnt, next_errCnt;
	logic rxPipe, next_rxPipe;
	logic [6:0] domCount, next_domCount;
	logic [6:0] domLimit;
	logic silenceSync, frameSync, analogSync, filteredSync;
	logic busTake, wrLane, wrHit, unlocked;
	logic [7:0] wrByte;
	logic [7:0] tolRead, optRead;
	logic hitPayloadOne, hitPayloadZero, hitTolerance;
	logic hitFineTrim, hitOptions, hitTrimEnable;
	logic rxSource;

	// silence and frame error idle low, the bus levels idle recessive high
	swr_sync #(
		.RESET_LEVEL(1'b0)
	) i_silence_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pinIn(silenceExpired),
		.pinSync(silenceSync)
	);

	swr_sync #(
		.RESET_LEVEL(1'b0)
	) i_frame_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pinIn(frameError),
		.pinSync(frameSync)
	);

	swr_sync #(
		.RESET_LEVEL(1'b1)
	) i_analog_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pinIn(rxAnalog),
		.pinSync(analogSync)
	);

	swr_sync #(
		.RESET_LEVEL(1'b1)
	) i_filtered_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pinIn(rxFiltered),
		.pinSync(filteredSync)
	);

	assign req = '{adr: wbAdr[9:2], we: wbWe, sel: wbSel, dat: wbDatIn};
	assign busTake = wbCyc && wbStb && state == SWR_IDLE;
	assign wrLane = req.sel[0];
	assign wrByte = req.dat[7:0];
	// a restart cycle drops the access, so no write can land during it
	assign wrHit = busTake && req.we && wrLane && !restart;
	assign unlocked = trimEnable == SWR_TRIM_UNLOCK;
	assign tolRead = {2'b00, tol}; // [R2]
	assign optRead = {rxSelect, 2'b00, coarseTrim}; // [R18]

	always_comb begin
		hitPayloadOne = 1'b0;
		hitPayloadZero = 1'b0;
		hitTolerance = 1'b0;
		hitFineTrim = 1'b0;
		hitOptions = 1'b0;
		hitTrimEnable = 1'b0;
		if (wrHit) begin
			case (req.adr)
				SWR_IDX_PAYLOAD_ONE: hitPayloadOne = 1'b1;
				SWR_IDX_PAYLOAD_ZERO: hitPayloadZero = 1'b1;
				SWR_IDX_TOLERANCE: hitTolerance = 1'b1;
				SWR_IDX_FINE_TRIM: hitFineTrim = 1'b1;
				SWR_IDX_OPTIONS: hitOptions = 1'b1;
				SWR_IDX_TRIM_ENABLE: hitTrimEnable = 1'b1;
				default: begin
				end
			endcase
		end
	end

	// unmapped indices read zero but are still acknowledged
	always_comb begin
		readWord = 32'h0000_0000;
		case (req.adr)
			SWR_IDX_PAYLOAD_ONE: readWord = {24'h00_0000, payloadOne};
			SWR_IDX_PAYLOAD_ZERO: readWord = {24'h00_0000, payloadZero};
			SWR_IDX_TOLERANCE: readWord = {24'h00_0000, tolRead};
			SWR_IDX_FINE_TRIM: readWord = {24'h00_0000, fineTrim};
			SWR_IDX_OPTIONS: readWord = {24'h00_0000, optRead};
			SWR_IDX_CAL_HIGH: readWord = {24'h00_0000, calHigh};
			SWR_IDX_CAL_LOW: readWord = {24'h00_0000, calLow};
			SWR_IDX_TRIM_ENABLE: readWord = {30'h0000_0000, trimEnable};
			SWR_IDX_STATUS: readWord = {24'h00_0000, errCnt};
			default: begin
				readWord = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		next_state = state;
		next_rdData = rdData;
		case (state)
			SWR_IDLE: begin
				if (busTake) begin
					next_state = SWR_ACK;
					next_rdData = readWord;
				end
			end
			SWR_ACK: begin
				next_state = SWR_IDLE;
			end
			default: begin
				next_state = SWR_IDLE;
			end
		endcase
		// restart abandons any access in flight
		if (restart) begin
			next_state = SWR_IDLE;
			next_rdData = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= SWR_IDLE;
			rdData <= 32'h0000_0000;
		end else begin
			state <= next_state;
			rdData <= next_rdData;
		end
	end

	always_comb begin
		next_payloadOne = payloadOne;
		next_payloadZero = payloadZero;
		if (hitPayloadOne) begin
			next_payloadOne = wrByte; // [R1]
		end
		if (hitPayloadZero) begin
			next_payloadZero = wrByte; // [R1]
		end
	end

	// payloads keep their contents across restart
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			payloadOne <= SWR_RESET_ZERO;
			payloadZero <= SWR_RESET_ZERO;
		end else begin
			payloadOne <= next_payloadOne;
			payloadZero <= next_payloadZero;
		end
	end

	always_comb begin
		next_tol = tol;
		if (hitTolerance) begin
			// bits 7:6 have no storage, so they can never be set
			next_tol = swr_tol_t'(wrByte[5:0] & SWR_TOL_WRITE_MASK[5:0]); // [R2] [R5] [R8]
		end
		// hardware clear wins over a same-cycle software set
		if (silenceSync) begin
			next_tol.errInhibit = 1'b0; // [R4]
		end
	end

	// restart keeps bits 5:0, the reserved bits read zero anyway
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tol <= swr_tol_t'(6'h00); // [R17]
		end else begin
			tol <= next_tol;
		end
	end

	always_comb begin
		next_fineTrim = fineTrim;
		next_rxSelect = rxSelect;
		next_coarseTrim = coarseTrim;
		next_trimEnable = trimEnable;
		if (hitFineTrim && unlocked) begin
			next_fineTrim = wrByte; // [R9] [R19]
		end
		if (hitOptions && unlocked) begin
			next_rxSelect = wrByte[SWR_BIT_RX_SELECT]; // [R12] [R19]
			next_coarseTrim = wrByte[4:0]; // [R15]
		end
		if (hitTrimEnable) begin
			next_trimEnable = wrByte[1:0];
		end
		// relocks the trim fields; the trims themselves are kept
		if (restart) begin
			next_trimEnable = 2'b00;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fineTrim <= SWR_FINE_TRIM_INIT;
			rxSelect <= 1'b0; // [R18]
			coarseTrim <= SWR_COARSE_TRIM_INIT;
			trimEnable <= 2'b00;
		end else begin
			fineTrim <= next_fineTrim;
			rxSelect <= next_rxSelect;
			coarseTrim <= next_coarseTrim;
			trimEnable <= next_trimEnable;
		end
	end

	always_comb begin
		next_calHigh = calHigh;
		next_calLow = calLow;
		if (calValid) begin
			next_calHigh = calHighIn; // [R16]
			next_calLow = calLowIn; // [R16]
		end
	end

	// calibration results survive restart
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			calHigh <= SWR_RESET_ZERO; // [R16]
			calLow <= SWR_RESET_ZERO; // [R16]
		end else begin
			calHigh <= next_calHigh;
			calLow <= next_calLow;
		end
	end

	// halted only when inhibit and tolerant mode are both set
	assign errorCountEnable = !(tol.errInhibit && tol.tolEnable); // [R3] [R8]

	// saturates rather than wraps, so a long error burst still reads full
	always_comb begin
		next_errCnt = errCnt;
		if (frameSync && errorCountEnable && errCnt != 8'hff) begin
			next_errCnt = errCnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			errCnt <= 8'h00;
		end else begin
			errCnt <= next_errCnt;
		end
	end

	// dominant filter: a dominant (low) level must persist the selected time
	always_comb begin
		if (tol.filterTime == SWR_FILTER_LONG_CODE) begin
			domLimit = 7'(SWR_FILTER_LONG_CYC); // [R6]
		end else begin
			domLimit = 7'((int'(tol.filterTime) + 1) * SWR_FILTER_STEP_CYC); // [R6]
		end
	end

	assign rxSource = tol.filterBypass ? analogSync : filteredSync; // [R5]

	always_comb begin
		next_domCount = domCount;
		next_rxPipe = rxPipe;
		// applied after the bypass mux, so it never drops out of the path
		if (rxSource) begin
			next_domCount = 7'h00; // [R7]
			next_rxPipe = 1'b1;
		end else if (domCount >= domLimit - 7'h01) begin
			next_rxPipe = 1'b0; // [R7]
		end else begin
			next_domCount = domCount + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			domCount <= 7'h00;
			rxPipe <= 1'b1;
		end else begin
			domCount <= next_domCount;
			rxPipe <= next_rxPipe;
		end
	end

	assign wbAck = state == SWR_ACK;
	assign wbDatOut = rdData;
	assign rxData = rxPipe;
	assign errorCount = errCnt;
	assign lowPowerReceiver = rxSelect; // [R12]
	assign oscillatorTrim = {coarseTrim, fineTrim}; // [R10] [R15]
endmodule

// [test/swr_regs_asserts.sv]
// port assertions for the selective-wake register bank
`timescale 1ns/1ns
module swr_regs_asserts import swr_pkg::*; (
	input logic clk, reset_n, restart, wbCyc, wbStb, wbWe, wbAck,
	input logic [9:0] wbAdr,
	input logic [3:0] wbSel,
	input logic [31:0] wbDatIn, wbDatOut,
	input logic errorCountEnable, lowPowerReceiver,
	input logic [7:0] errorCount,
	input logic [12:0] oscillatorTrim
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire take = wbCyc && wbStb && !wbAck;
	wire wr = take && wbWe;
	wire [7:0] idx = wbAdr[9:2];
	a_ack_next: assert property (take && !restart |=> wbAck) else $error("ack missing");
	a_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack too long");
	a_ack_unasked: assert property (!(wbCyc && wbStb) |=> !wbAck) else $error("stray ack");
	a_upper_zero: assert property (wbAck |-> wbDatOut[31:8] == 24'h0) else $error("upper data");
	a_tol_reserved: assert property (wbAck && idx == SWR_IDX_TOLERANCE |-> wbDatOut[7:6] == 2'h0)
		else $error("tolerance reserved bits set");
	a_opt_reserved: assert property (wbAck && idx == SWR_IDX_OPTIONS |-> wbDatOut[6:5] == 2'h0)
		else $error("options reserved bits set");
	a_trim_hold: assert property (!(wr && (idx == SWR_IDX_FINE_TRIM || idx == SWR_IDX_OPTIONS))
		|=> $stable(oscillatorTrim)) else $error("trim moved");
	a_rxsel_hold: assert property (!(wr && idx == SWR_IDX_OPTIONS)
		|=> $stable(lowPowerReceiver)) else $error("receiver select moved");
	a_count_frozen: assert property (!errorCountEnable && !restart |=> $stable(errorCount))
		else $error("counter ran while inhibited");
	a_tol_off: assert property (wr && !restart && wbSel[0] && idx == SWR_IDX_TOLERANCE
		&& !wbDatIn[0] |=> errorCountEnable) else $error("counter off while tolerance off");
	c_opt_write: cover property (wr && idx == SWR_IDX_OPTIONS);
	c_count_full: cover property (errorCount == 8'hff);
	c_low_power: cover property ($rose(lowPowerReceiver));
endmodule
bind swr_regs swr_regs_asserts i_swr_regs_asserts(.clk, .reset_n, .restart, .wbCyc, .wbStb,
	.wbWe, .wbAck, .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .errorCountEnable, .lowPowerReceiver,
	.errorCount, .oscillatorTrim);

// [test/swr_regs_tb.sv]
// self-checking bench for the selective-wake register bank
`timescale 1ns/1ns
module swr_regs_tb import swr_pkg::*; ;
	logic clk = 0, reset_n = 0, restart = 0, wbCyc = 0, wbStb = 0, wbWe = 0, frameError = 0;
	logic silenceExpired = 0, rxAnalog = 1, rxFiltered = 1, calValid = 0, seenLow = 0;
	logic rxData, errorCountEnable, lowPowerReceiver, wbAck;
	logic [9:0] wbAdr = 0;
	logic [3:0] sel = 4'h1;
	logic [31:0] wbDatIn = 0, wbDatOut;
	logic [7:0] calHighIn = 0, calLowIn = 0, errorCount, q;
	logic [12:0] oscillatorTrim;
	int num_errors = 0, compares = 0, n, k;
	swr_regs i_swr_regs(.clk, .reset_n, .restart, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel(sel),
		.wbDatIn, .wbDatOut, .wbAck, .silenceExpired, .frameError, .rxAnalog, .rxFiltered,
		.calValid, .calHighIn, .calLowIn, .rxData, .errorCountEnable, .errorCount,
		.lowPowerReceiver, .oscillatorTrim);
	always #5 clk = ~clk;
	always @(posedge clk) if (rxData === 1'h0) seenLow <= 1'h1;
	task chk(input string s, input logic [31:0] v, e);
		compares++;
		if (v !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", s, e, v);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, d);
		@(posedge clk);
		wbCyc <= 1'h1;
		wbStb <= 1'h1;
		wbWe <= w;
		wbAdr <= {a, 2'h0};
		wbDatIn <= {24'h0, d};
		do @(posedge clk); while (wbAck !== 1'h1);
		q = wbDatOut[7:0];
		wbCyc <= 1'h0;
		wbStb <= 1'h0;
	endtask
	task rd(input logic [7:0] a, e, input string s);
		wb(1'h0, a, 8'h00);
		chk(s, q, e);
	endtask
	// inputs pass a synchroniser, so let them drain before reading
	task fe(input int c);
		@(posedge clk);
		frameError <= 1'h1;
		repeat (c) @(posedge clk);
		frameError <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	// only the selected path goes low, so a wrong path choice shows
	task pulse(input logic byp, input int c);
		seenLow = 1'h0;
		@(posedge clk);
		if (byp) rxAnalog <= 1'h0;
		else rxFiltered <= 1'h0;
		repeat (c) @(posedge clk);
		rxAnalog <= 1'h1;
		rxFiltered <= 1'h1;
		repeat (10) @(posedge clk);
	endtask
	task summarize;
		$display("mismatches %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#500000;
		num_errors++;
		summarize;
	end
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'h1;
		rd(SWR_IDX_TOLERANCE, 8'h00, "tol");
		rd(SWR_IDX_CAL_HIGH, 8'h00, "calh");
		rd(SWR_IDX_CAL_LOW, 8'h00, "call");
		rd(SWR_IDX_OPTIONS, {3'h0, SWR_COARSE_TRIM_INIT}, "opt");
		wb(1'h1, SWR_IDX_PAYLOAD_ONE, 8'ha5);
		wb(1'h1, SWR_IDX_PAYLOAD_ZERO, 8'h5a);
		wb(1'h1, 8'h3c, 8'hff);
		sel <= 4'h0;
		wb(1'h1, SWR_IDX_PAYLOAD_ONE, 8'h00);
		sel <= 4'h1;
		rd(SWR_IDX_PAYLOAD_ONE, 8'ha5, "p1");
		rd(SWR_IDX_PAYLOAD_ZERO, 8'h5a, "p0");
		rd(8'h3c, 8'h00, "unmapped");
		wb(1'h1, SWR_IDX_TOLERANCE, 8'hff);
		rd(SWR_IDX_TOLERANCE, 8'h3f, "tol");
		chk("ecen", errorCountEnable, 1'h0);
		wb(1'h1, SWR_IDX_TOLERANCE, 8'h20);
		chk("ecen", errorCountEnable, 1'h1);
		wb(1'h1, SWR_IDX_TOLERANCE, 8'h21);
		fe(20);
		rd(SWR_IDX_STATUS, 8'h00, "cnt");
		@(posedge clk);
		silenceExpired <= 1'h1;
		repeat (4) @(posedge clk);
		silenceExpired <= 1'h0;
		rd(SWR_IDX_TOLERANCE, 8'h01, "tol");
		fe(300);
		rd(SWR_IDX_STATUS, 8'hff, "cnt");
		chk("cntport", errorCount, 8'hff);
		wb(1'h1, SWR_IDX_FINE_TRIM, 8'h1c);
		wb(1'h1, SWR_IDX_OPTIONS, 8'hff);
		chk("trim", oscillatorTrim, {SWR_COARSE_TRIM_INIT, SWR_FINE_TRIM_INIT});
		chk("lpr", lowPowerReceiver, 1'h0);
		wb(1'h1, SWR_IDX_TRIM_ENABLE, {6'h0, SWR_TRIM_UNLOCK});
		wb(1'h1, SWR_IDX_FINE_TRIM, 8'h1c);
		wb(1'h1, SWR_IDX_OPTIONS, {3'h4, SWR_COARSE_TRIM_INIT});
		rd(SWR_IDX_FINE_TRIM, 8'h1c, "fine");
		rd(SWR_IDX_OPTIONS, 8'h90, "opt");
		chk("trim", oscillatorTrim, 13'h101c);
		chk("lpr", lowPowerReceiver, 1'h1);
		wb(1'h1, SWR_IDX_TOLERANCE, 8'h3f);
		@(posedge clk);
		calHighIn <= 8'hc3;
		calLowIn <= 8'h3c;
		calValid <= 1'h1;
		@(posedge clk);
		calValid <= 1'h0;
		restart <= 1'h1;
		@(posedge clk);
		restart <= 1'h0;
		rd(SWR_IDX_TOLERANCE, 8'h3f, "tol");
		rd(SWR_IDX_OPTIONS, 8'h90, "opt");
		rd(SWR_IDX_CAL_HIGH, 8'hc3, "calh");
		rd(SWR_IDX_CAL_LOW, 8'h3c, "call");
		wb(1'h1, SWR_IDX_FINE_TRIM, 8'h00);
		chk("trim", oscillatorTrim, 13'h101c);
		for (n = 0; n < 8; n++) begin
			wb(1'h1, SWR_IDX_TOLERANCE, {3'h0, n[0], n[2:0], 1'h0});
			k = (n == 7) ? SWR_FILTER_LONG_CYC : SWR_FILTER_STEP_CYC * (n + 1);
			pulse(n[0], k - 2);
			chk("rxshort", seenLow, 1'h0);
			pulse(n[0], k + 6);
			chk("rxlong", seenLow, 1'h1);
		end
		reset_n <= 1'h0;
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		rd(SWR_IDX_TOLERANCE, 8'h00, "tol");
		rd(SWR_IDX_CAL_HIGH, 8'h00, "calh");
		wb(1'h0, SWR_IDX_OPTIONS, 8'h00);
		chk("opt", q & 8'he0, 8'h00);
		summarize;
	end
endmodule
